/* File: gpio_cfg_pkg.sv */
// Purpose: Shared constants for the general-purpose pin block.
// Assumes: Pins are held in slots numbered port*8+pin; unused slots stay idle.
// Notes:   Runtime offsets are byte offsets inside a 32-byte window.
package gpio_cfg_pkg;

   localparam int NUM_PINS   = 51;
   localparam int PIN_SLOTS  = 56;
   localparam int EVENT_PINS = 16;

   // Slot masks: pins that exist, pins with an input path, event-capable pins.
   localparam logic [55:0] PIN_PRESENT   = 56'h1f3fffffffffff;
   localparam logic [55:0] INPUT_PRESENT = 56'h003fffffffffff;
   localparam logic [55:0] EVENT_PRESENT = 56'h0000ff0000ff00;
   localparam logic [55:0] PULLUP_DEFAULT = 56'h00000000000000;

   // Runtime register offsets.
   localparam logic [4:0] RT_P0_DO = 5'h00;
   localparam logic [4:0] RT_P0_DI = 5'h01;
   localparam logic [4:0] RT_P1_DO = 5'h02;
   localparam logic [4:0] RT_P1_DI = 5'h03;
   localparam logic [4:0] RT_P1_EN = 5'h04;
   localparam logic [4:0] RT_P1_ST = 5'h05;
   localparam logic [4:0] RT_P2_DO = 5'h06;
   localparam logic [4:0] RT_P2_DI = 5'h07;
   localparam logic [4:0] RT_P3_DO = 5'h08;
   localparam logic [4:0] RT_P3_DI = 5'h09;
   localparam logic [4:0] RT_P4_DO = 5'h0a;
   localparam logic [4:0] RT_P4_DI = 5'h0b;
   localparam logic [4:0] RT_P4_EN = 5'h0c;
   localparam logic [4:0] RT_P4_ST = 5'h0d;
   localparam logic [4:0] RT_P5_DO = 5'h0e;
   localparam logic [4:0] RT_P5_DI = 5'h0f;
   localparam logic [4:0] RT_P6_DO = 5'h10;

   // Configuration indexes.
   localparam logic [7:0] IDX_ACT     = 8'h30;
   localparam logic [7:0] IDX_BASE_HI = 8'h60;
   localparam logic [7:0] IDX_BASE_LO = 8'h61;
   localparam logic [7:0] IDX_IRQ_NUM = 8'h70;
   localparam logic [7:0] IDX_IRQ_TYP = 8'h71;
   localparam logic [7:0] IDX_DMA_A   = 8'h74;
   localparam logic [7:0] IDX_DMA_B   = 8'h75;
   localparam logic [7:0] IDX_SEL     = 8'hf0;
   localparam logic [7:0] IDX_CFG1    = 8'hf1;
   localparam logic [7:0] IDX_EVR     = 8'hf2;
   localparam logic [7:0] IDX_CFG2    = 8'hf3;

   // Reset values.
   localparam logic [7:0] ACT_RST       = 8'h00;
   localparam logic [7:0] BASE_HI_RST   = 8'h00;
   localparam logic [7:0] BASE_LO_RST   = 8'h00;
   localparam logic [7:0] IRQ_NUM_RST   = 8'h00;
   localparam logic [7:0] IRQ_TYP_RST   = 8'h03;
   localparam logic [7:0] DMA_RPT_VAL   = 8'h04;
   localparam logic [7:0] SEL_RST       = 8'h00;
   localparam logic [7:0] EVR_RST       = 8'h01;
   localparam logic [7:0] CFG2_RST      = 8'h00;
   localparam logic [7:0] CFG_EV_RST    = 8'h40;
   localparam logic [7:0] CFG_PLAIN_RST = 8'h00;
   localparam logic [7:0] DO_RST        = 8'h00;

   // Field positions and masks.
   localparam int BIT_DBNC  = 6;
   localparam int BIT_POL   = 5;
   localparam int BIT_TYPE  = 4;
   localparam int BIT_LOCK  = 3;
   localparam int BIT_PUP   = 2;
   localparam int BIT_OTYPE = 1;
   localparam int BIT_OEN   = 0;
   localparam int BIT_ACT   = 0;
   localparam int BIT_EVR_IRQ = 0;
   localparam int BIT_EVR_SMI = 1;
   localparam int BIT_IRQ_POL = 1;
   localparam logic [7:0] SEL_MASK       = 8'h77;
   localparam logic [7:0] BASE_LO_MASK   = 8'he0;
   localparam logic [7:0] IRQ_TYP_WMASK  = 8'h02;
   localparam logic [7:0] CFG_EV_WMASK   = 8'h70;
   localparam logic [2:0] PORT_LAST      = 3'h6;

   // Timing.
   localparam int CLK_PERIOD_PS    = 5000;
   localparam int DEBOUNCE_TIME_NS = 10000;
   localparam int DEBOUNCE_CYCLES  =
      (DEBOUNCE_TIME_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int DB_CNT_W = 12;

endpackage

/* File: pin_event_detect.sv */
// Purpose: Debounce and edge or level event detection for one event pin.
// Assumes: level_in is already synchronised to clk_sys_in.
// Notes:   The first five samples after reset only load state, so no false edge.
`timescale 1ns/1ps
module pin_event_detect (
   input  wire logic clk_sys_in,
   input  wire logic ce_in,
   input  wire logic srst_in,
   input  wire logic level_in,
   input  wire logic debounce_en_in,
   input  wire logic polarity_in,
   input  wire logic level_mode_in,
   output logic      event_out
);
   import gpio_cfg_pkg::*;

   logic [DB_CNT_W-1:0] cnt_r;
   logic                db_r;
   logic                init_r;
   logic                commit;

   localparam logic [DB_CNT_W-1:0] DB_LAST = DB_CNT_W'(DEBOUNCE_CYCLES - 1);

   // With debounce on, a new level is taken only after it held for the whole period; with it off, at once.
   assign commit = (level_in != db_r) && (!debounce_en_in || cnt_r == DB_LAST);

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         cnt_r  <= '0;
         db_r   <= 1'b1;
         init_r <= 1'b1;
      end else if (ce_in) begin
         init_r <= init_r && !cnt_r[2];
         if (init_r || commit) begin
            db_r  <= level_in;
            cnt_r <= (init_r && !cnt_r[2]) ? cnt_r + 1'b1 : '0;
         end else if (level_in != db_r) begin
            cnt_r <= cnt_r + 1'b1;
         end else begin
            cnt_r <= '0;
         end
      end
   end

   // Edge mode fires once on a committed change towards the polarity; level
   // mode holds while the filtered level equals it.
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         event_out <= 1'b0;
      end else if (ce_in) begin
         if (init_r) begin
            event_out <= 1'b0;
         end else if (level_mode_in) begin
            event_out <= (db_r == polarity_in);
         end else begin
            event_out <= commit && (level_in == polarity_in);
         end
      end
   end

endmodule

/* File: gpio_port_config_runtime.sv */
// Purpose: Pin ports with runtime registers and indexed configuration.
// Assumes: srst_in is main-power reset, stby_srst_in is standby-well reset.
// Notes:   Reads answer one cycle after the strobe; pins live in port*8+pin slots.
// Function
// - Fifty-one pins in seven ports: five of eight, one of six, one of five.
// - Ports 1 and 4 detect events that raise the host or management interrupt.
// - Ports 0 to 5 are bidirectional; port 6 pins are outputs only.
// - Runtime window is 32-byte aligned; address bits 4-0 pick the register.
// - Ports 1 and 4 have four runtime registers, others two, port 6 one.
// - Low base-address bits 4-0 read zero and ignore writes.
// - Interrupt type: only bit 1 writable, reset value 03h.
// - Standard registers reset with main power, pin registers with standby.
// - Separate pin selectors for host and serial management accesses.
// - Pin selector resets to 00h, port 0 pin 0.
// - Port field codes 0 to 6 pick ports; code 7 must not be used.
// - Pin field bits 2-0 give the pin number 0 to 7.
// - Pin configuration accesses act on the currently selected pin.
// - Config resets to 01000X00b on ports 1 and 4, else 00000X00b.
// - Event routing at index F2h is standby, read/write, reset 01h.
// - Event pin config bits 6-0: debounce, polarity, type, lock, pull-up, type, enable.
// - Lock is set-only and freezes lower config, second config and data bit.
// - Output type 0 open-drain, 1 push-pull; enable 0 floats, 1 drives.
// - Polarity 0 falling or low, 1 rising or high; type 0 edge, 1 level.
// - With debounce on, an event needs the input stable for the period.
`timescale 1ns/1ps
module gpio_port_config_runtime (
   input  wire logic        clk_sys_in,
   input  wire logic        ce_in,
   input  wire logic        srst_in,
   input  wire logic        stby_srst_in,
   input  wire logic [15:0] rt_addr_in,
   input  wire logic        rt_wr_in,
   input  wire logic        rt_rd_in,
   input  wire logic [7:0]  rt_wdata_in,
   output logic      [7:0]  rt_rdata_out,
   input  wire logic        cfg_src_in,
   input  wire logic [7:0]  cfg_index_in,
   input  wire logic        cfg_wr_in,
   input  wire logic        cfg_rd_in,
   input  wire logic [7:0]  cfg_wdata_in,
   output logic      [7:0]  cfg_rdata_out,
   input  wire logic [gpio_cfg_pkg::PIN_SLOTS-1:0] pin_in,
   output logic      [gpio_cfg_pkg::PIN_SLOTS-1:0] pin_drive_out,
   output logic      [gpio_cfg_pkg::PIN_SLOTS-1:0] pin_oe_out,
   output logic      [gpio_cfg_pkg::PIN_SLOTS-1:0] pullup_en_out,
   output logic             irq_out,
   output logic             system_management_interrupt_out
);
   import gpio_cfg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // State.

   logic [7:0]  act_r;
   logic [7:0]  base_hi_r;
   logic [7:0]  base_lo_r;
   logic [7:0]  irq_num_r;
   logic [7:0]  irq_typ_r;
   logic [7:0]  sel_r [2];
   logic [7:0]  cfg1_r [PIN_SLOTS];
   logic [7:0]  cfg2_r [PIN_SLOTS];
   logic [7:0]  evr_r [PIN_SLOTS];
   logic [PIN_SLOTS-1:0]  out_r;
   logic [PIN_SLOTS-1:0]  s1_r;
   logic [PIN_SLOTS-1:0]  s2_r;
   logic [PIN_SLOTS-1:0]  s3_r;
   logic [PIN_SLOTS-1:0]  lvl_r;
   logic [EVENT_PINS-1:0] ev_en_r;
   logic [EVENT_PINS-1:0] ev_st_r;

   logic                  rt_hit;
   logic [4:0]            rt_off;
   logic [PIN_SLOTS-1:0]  lock_vec;
   logic [PIN_SLOTS-1:0]  do_wmask;
   logic [EVENT_PINS-1:0] st_clr;
   logic [EVENT_PINS-1:0] en_wmask;
   logic [EVENT_PINS-1:0] ev_vec;
   logic [EVENT_PINS-1:0] route_irq;
   logic [EVENT_PINS-1:0] route_smi;
   logic [7:0]            rt_rd_val;
   logic [7:0]            cfg_rd_val;
   logic [7:0]            cur_sel;
   logic [5:0]            slot;
   logic                  slot_ok;
   logic                  slot_lock;
   logic [7:0]            cfg1_wval;
   logic                  cfg_wr_main;

   ////////////////////////////////////////////////////////////////////////////
   // Runtime window decode.

   // Only bits 15-5 are compared, so the window is always 32-byte aligned.
   assign rt_hit = act_r[BIT_ACT] && (rt_addr_in[15:5] == {base_hi_r, base_lo_r[7:5]});
   assign rt_off = rt_addr_in[4:0];

   always_comb begin
      for (int s = 0; s < PIN_SLOTS; s++) begin
         lock_vec[s] = cfg1_r[s][BIT_LOCK];
      end
   end

   // Absent pins and locked pins never take a data write.
   always_comb begin
      do_wmask = '0;
      en_wmask = '0;
      st_clr   = '0;
      if (rt_wr_in && rt_hit) begin
         case (rt_off)
            RT_P0_DO: do_wmask[7:0]   = 8'hff;
            RT_P1_DO: do_wmask[15:8]  = 8'hff;
            RT_P2_DO: do_wmask[23:16] = 8'hff;
            RT_P3_DO: do_wmask[31:24] = 8'hff;
            RT_P4_DO: do_wmask[39:32] = 8'hff;
            RT_P5_DO: do_wmask[47:40] = 8'hff;
            RT_P6_DO: do_wmask[55:48] = 8'hff;
            RT_P1_EN: en_wmask[7:0]   = 8'hff;
            RT_P4_EN: en_wmask[15:8]  = 8'hff;
            RT_P1_ST: st_clr[7:0]     = rt_wdata_in;
            RT_P4_ST: st_clr[15:8]    = rt_wdata_in;
            default:  do_wmask        = '0;
         endcase
      end
      do_wmask = do_wmask & PIN_PRESENT & ~lock_vec;
   end

   always_ff @(posedge clk_sys_in) begin
      if (stby_srst_in) begin
         out_r   <= '0;
         ev_en_r <= '0;
      end else if (ce_in) begin
         out_r   <= (out_r & ~do_wmask) | ({7{rt_wdata_in}} & do_wmask);
         ev_en_r <= (ev_en_r & ~en_wmask) | ({2{rt_wdata_in}} & en_wmask);
      end
   end

   // A new event wins over a clear in the same cycle.
   always_ff @(posedge clk_sys_in) begin
      if (stby_srst_in) begin
         ev_st_r <= '0;
      end else if (ce_in) begin
         ev_st_r <= (ev_st_r & ~st_clr) | ev_vec;
      end
   end

   // Each port shows only its own registers; port 6 has no input.
   always_comb begin
      case (rt_off)
         RT_P0_DO: rt_rd_val = out_r[7:0];
         RT_P0_DI: rt_rd_val = lvl_r[7:0];
         RT_P1_DO: rt_rd_val = out_r[15:8];
         RT_P1_DI: rt_rd_val = lvl_r[15:8];
         RT_P1_EN: rt_rd_val = ev_en_r[7:0];
         RT_P1_ST: rt_rd_val = ev_st_r[7:0];
         RT_P2_DO: rt_rd_val = out_r[23:16];
         RT_P2_DI: rt_rd_val = lvl_r[23:16];
         RT_P3_DO: rt_rd_val = out_r[31:24];
         RT_P3_DI: rt_rd_val = lvl_r[31:24];
         RT_P4_DO: rt_rd_val = out_r[39:32];
         RT_P4_DI: rt_rd_val = lvl_r[39:32];
         RT_P4_EN: rt_rd_val = ev_en_r[15:8];
         RT_P4_ST: rt_rd_val = ev_st_r[15:8];
         RT_P5_DO: rt_rd_val = out_r[47:40];
         RT_P5_DI: rt_rd_val = lvl_r[47:40];
         RT_P6_DO: rt_rd_val = out_r[55:48];
         default:  rt_rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (stby_srst_in) begin
         rt_rdata_out <= 8'h00;
      end else if (ce_in && rt_rd_in) begin
         rt_rdata_out <= rt_hit ? rt_rd_val : 8'h00;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin input synchroniser and event detectors.

   // A change is accepted only once the second and third stages agree.
   always_ff @(posedge clk_sys_in) begin
      if (stby_srst_in) begin
         s1_r  <= '0;
         s2_r  <= '0;
         s3_r  <= '0;
         lvl_r <= '0;
      end else if (ce_in) begin
         s1_r  <= pin_in & INPUT_PRESENT;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         lvl_r <= ((s2_r ~^ s3_r) & s3_r) | ((s2_r ^ s3_r) & lvl_r);
      end
   end

   // Event pins are ports 1 and 4: slots 8-15 and 32-39.
   for (genvar e = 0; e < EVENT_PINS; e++) begin : g_ev
      localparam int SLOT = (e < 8) ? (8 + e) : (24 + e);
      pin_event_detect u_det (
         .clk_sys_in     (clk_sys_in),
         .ce_in          (ce_in),
         .srst_in        (stby_srst_in),
         .level_in       (lvl_r[SLOT]),
         .debounce_en_in (cfg1_r[SLOT][BIT_DBNC]),
         .polarity_in    (cfg1_r[SLOT][BIT_POL]),
         .level_mode_in  (cfg1_r[SLOT][BIT_TYPE]),
         .event_out      (ev_vec[e])
      );
      assign route_irq[e] = evr_r[SLOT][BIT_EVR_IRQ];
      assign route_smi[e] = evr_r[SLOT][BIT_EVR_SMI];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Configuration access.

   // Each bus has its own selector so interleaved sequences stay apart.
   assign cur_sel   = sel_r[cfg_src_in];
   assign slot_ok   = (cur_sel[6:4] <= PORT_LAST);
   // Slot is port*8+pin straight from the two fields.
   assign slot      = slot_ok ? {cur_sel[6:4], cur_sel[2:0]} : 6'h00;
   assign slot_lock = cfg1_r[slot][BIT_LOCK];

   always_comb begin
      cfg1_wval = 8'h00;
      if (EVENT_PRESENT[slot]) begin
         cfg1_wval = cfg_wdata_in & CFG_EV_WMASK;
      end
      cfg1_wval[BIT_LOCK] = slot_lock | cfg_wdata_in[BIT_LOCK];
      if (slot_lock) begin
         cfg1_wval[2:0] = cfg1_r[slot][2:0];
      end else begin
         cfg1_wval[2:0] = cfg_wdata_in[2:0];
      end
   end

   // Selectors and pin registers sit in the standby well.
   always_ff @(posedge clk_sys_in) begin
      if (stby_srst_in) begin
         sel_r[0] <= SEL_RST;
         sel_r[1] <= SEL_RST;
      end else if (ce_in && cfg_wr_in && cfg_index_in == IDX_SEL) begin
         sel_r[cfg_src_in] <= cfg_wdata_in & SEL_MASK;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (stby_srst_in) begin
         for (int s = 0; s < PIN_SLOTS; s++) begin
            // Pull-up default is per pin.
            cfg1_r[s] <= (EVENT_PRESENT[s] ? CFG_EV_RST : CFG_PLAIN_RST)
                         | {5'h00, PULLUP_DEFAULT[s], 2'b00};
            cfg2_r[s] <= CFG2_RST;
            evr_r[s]  <= EVENT_PRESENT[s] ? EVR_RST : 8'h00;
         end
      end else if (ce_in && cfg_wr_in && slot_ok && PIN_PRESENT[slot]) begin
         if (cfg_index_in == IDX_CFG1) begin
            cfg1_r[slot] <= cfg1_wval;
         end
         if (cfg_index_in == IDX_CFG2 && !slot_lock) begin
            cfg2_r[slot] <= cfg_wdata_in;
         end
         if (cfg_index_in == IDX_EVR && EVENT_PRESENT[slot]) begin
            evr_r[slot] <= cfg_wdata_in;
         end
      end
   end

   // Standard registers follow main power.
   assign cfg_wr_main = ce_in && cfg_wr_in;

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         act_r     <= ACT_RST;
         base_hi_r <= BASE_HI_RST;
         base_lo_r <= BASE_LO_RST;
         irq_num_r <= IRQ_NUM_RST;
         irq_typ_r <= IRQ_TYP_RST;
      end else if (cfg_wr_main) begin
         case (cfg_index_in)
            IDX_ACT:     act_r     <= cfg_wdata_in;
            IDX_BASE_HI: base_hi_r <= cfg_wdata_in;
            IDX_BASE_LO: base_lo_r <= cfg_wdata_in & BASE_LO_MASK;
            IDX_IRQ_NUM: irq_num_r <= cfg_wdata_in;
            // Only bit 1 takes a write.
            IDX_IRQ_TYP: irq_typ_r <= (irq_typ_r & ~IRQ_TYP_WMASK)
                                      | (cfg_wdata_in & IRQ_TYP_WMASK);
            default:     act_r     <= act_r;
         endcase
      end
   end

   always_comb begin
      case (cfg_index_in)
         IDX_ACT:     cfg_rd_val = act_r;
         IDX_BASE_HI: cfg_rd_val = base_hi_r;
         IDX_BASE_LO: cfg_rd_val = base_lo_r;
         IDX_IRQ_NUM: cfg_rd_val = irq_num_r;
         IDX_IRQ_TYP: cfg_rd_val = irq_typ_r;
         IDX_DMA_A:   cfg_rd_val = DMA_RPT_VAL;
         IDX_DMA_B:   cfg_rd_val = DMA_RPT_VAL;
         IDX_SEL:     cfg_rd_val = cur_sel;
         IDX_CFG1:    cfg_rd_val = slot_ok ? cfg1_r[slot] : 8'h00;
         IDX_EVR:     cfg_rd_val = slot_ok ? evr_r[slot] : 8'h00;
         IDX_CFG2:    cfg_rd_val = slot_ok ? cfg2_r[slot] : 8'h00;
         default:     cfg_rd_val = 8'h00;
      endcase
   end

   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         cfg_rdata_out <= 8'h00;
      end else if (ce_in && cfg_rd_in) begin
         cfg_rdata_out <= cfg_rd_val;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Pin drivers and interrupts.

   // Open-drain only enables the driver while driving low, so the pin floats
   // high through the pull-up instead of fighting other drivers.
   always_ff @(posedge clk_sys_in) begin
      if (stby_srst_in) begin
         pin_drive_out <= '0;
         pin_oe_out    <= '0;
         pullup_en_out <= '0;
      end else if (ce_in) begin
         for (int s = 0; s < PIN_SLOTS; s++) begin
            pin_drive_out[s] <= out_r[s] & PIN_PRESENT[s];
            pin_oe_out[s]    <= PIN_PRESENT[s] & cfg1_r[s][BIT_OEN]
                                & (cfg1_r[s][BIT_OTYPE] | ~out_r[s]);
            pullup_en_out[s] <= PIN_PRESENT[s] & cfg1_r[s][BIT_PUP];
         end
      end
   end

   // Bit 1 of the interrupt type picks the active level of irq_out.
   always_ff @(posedge clk_sys_in) begin
      if (srst_in) begin
         irq_out <= 1'b0;
         system_management_interrupt_out <= 1'b0;
      end else if (ce_in) begin
         irq_out <= ~((act_r[BIT_ACT] && |(ev_st_r & ev_en_r & route_irq))
                      ^ irq_typ_r[BIT_IRQ_POL]);
         system_management_interrupt_out <= |(ev_st_r & ev_en_r & route_smi);
      end
   end

endmodule

/* File: gpio_port_config_runtime_asserts.sv */
// Purpose: Port-level checks on the pin block.
// Assumes: Only the top-level ports are visible here.
// Notes:   Read answers are judged one cycle after the strobe edge.
`timescale 1ns/1ps
module gpio_port_config_runtime_asserts (
   input wire logic                                clk_sys_in,
   input wire logic                                ce_in,
   input wire logic                                srst_in,
   input wire logic                                stby_srst_in,
   input wire logic                                rt_rd_in,
   input wire logic                                cfg_rd_in,
   input wire logic                                cfg_wr_in,
   input wire logic [7:0]                          cfg_index_in,
   input wire logic [7:0]                          cfg_rdata_out,
   input wire logic [7:0]                          rt_rdata_out,
   input wire logic [gpio_cfg_pkg::PIN_SLOTS-1:0]  pin_drive_out,
   input wire logic [gpio_cfg_pkg::PIN_SLOTS-1:0]  pin_oe_out,
   input wire logic [gpio_cfg_pkg::PIN_SLOTS-1:0]  pullup_en_out,
   input wire logic                                irq_out,
   input wire logic                                system_management_interrupt_out
);
   import gpio_cfg_pkg::*;
   default clocking cb @(posedge clk_sys_in); endclocking

   a_irq_type_ro: assert property (
      ce_in && cfg_rd_in && !srst_in && cfg_index_in == IDX_IRQ_TYP
      |=> cfg_rdata_out[7:2] == 6'h00 && cfg_rdata_out[0]) else $error("irq type fixed bits");
   a_base_lo_zero: assert property (
      ce_in && cfg_rd_in && !srst_in && cfg_index_in == IDX_BASE_LO
      |=> cfg_rdata_out[4:0] == 5'h00) else $error("base low bits not zero");
   a_sel_spare_zero: assert property (
      ce_in && cfg_rd_in && !srst_in && cfg_index_in == IDX_SEL
      |=> !cfg_rdata_out[7] && !cfg_rdata_out[3]) else $error("selector spare bits set");
   a_cfg_read_hold: assert property (
      !(ce_in && cfg_rd_in) && !srst_in |=> $stable(cfg_rdata_out)) else $error("cfg data moved");
   a_rt_read_hold: assert property (
      !(ce_in && rt_rd_in) && !stby_srst_in |=> $stable(rt_rdata_out)) else $error("rt data moved");
   a_main_reset_irq: assert property (
      srst_in && ce_in |=> !irq_out && !system_management_interrupt_out) else $error("irq after reset");
   a_stby_reset_pins: assert property (
      stby_srst_in && ce_in |=> pin_oe_out == '0 && pullup_en_out == '0 && pin_drive_out == '0)
      else $error("pins not idle after standby reset");
   a_absent_pins_idle: assert property (disable iff (stby_srst_in)
      ((pin_oe_out | pin_drive_out | pullup_en_out) & ~PIN_PRESENT) == '0)
      else $error("absent pin slot active");

   c_rt_read: cover property (ce_in && rt_rd_in);
   c_irq_rise: cover property ($rose(irq_out));
   c_cfg_pin_write: cover property (ce_in && cfg_wr_in && cfg_index_in == IDX_CFG1);
endmodule

bind gpio_port_config_runtime gpio_port_config_runtime_asserts u_chk (.clk_sys_in, .ce_in,
   .srst_in, .stby_srst_in, .rt_rd_in, .cfg_rd_in, .cfg_wr_in, .cfg_index_in, .cfg_rdata_out,
   .rt_rdata_out, .pin_drive_out, .pin_oe_out, .pullup_en_out, .irq_out,
   .system_management_interrupt_out);

/* File: gpio_pin_partner.sv */
// Purpose: Behavioural model of the devices and wiring on the pins.
// Assumes: An external driver never fights a pin that the block drives.
// Notes:   A floating pin without pull-up toggles, so no stale level is read.
`timescale 1ns/1ps
module gpio_pin_partner (
   input  wire logic        clk_sys_in,
   input  wire logic [55:0] drive_in,
   input  wire logic [55:0] oe_in,
   input  wire logic [55:0] pullup_in,
   input  wire logic [55:0] ext_in,
   input  wire logic [55:0] ext_oe_in,
   output logic      [55:0] level_out
);
   logic [55:0] float_r = '0;
   always @(posedge clk_sys_in) begin
      float_r <= ~float_r;
   end
   // The block's own enable wins; open-drain is already folded into its enable.
   always_comb begin
      level_out = (oe_in & drive_in) | (~oe_in & ext_oe_in & ext_in)
         | (~oe_in & ~ext_oe_in & (pullup_in | float_r));
   end
endmodule

/* File: testbench.sv */
// Purpose: Self-checking bench for the pin block.
// Assumes: Runtime window placed at 0a40h and activated by the table.
// Notes:   Debounce is switched off on the event pin to keep the run short.
`timescale 1ns/1ps
`define CHK(n, e, a) begin n_compared++; if ((a) !== (e)) begin fails++; \
   $display("[ERR] %s exp %h got %h", n, e, a); end end
module testbench;
   import gpio_cfg_pkg::*;
   localparam logic [15:0] RT_BASE = 16'h0a40;
   typedef struct {logic [7:0] i, d, e;} row_s;
   logic        clk_sys_in, ce_in, srst_in, stby_srst_in, rt_wr_in, rt_rd_in;
   logic        cfg_src_in, cfg_wr_in, cfg_rd_in, irq_out, system_management_interrupt_out;
   logic [15:0] rt_addr_in;
   logic [7:0]  rt_wdata_in, rt_rdata_out, cfg_index_in, cfg_wdata_in, cfg_rdata_out;
   logic [55:0] pin_in, pin_drive_out, pin_oe_out, pullup_en_out, ext_in, ext_oe_in;
   int          fails, n_compared;
   row_s        rows [13] = '{
      '{8'h30, 8'h01, 8'h01}, '{8'h60, 8'h0a, 8'h0a}, '{8'h61, 8'h5f, 8'h40},
      '{8'h70, 8'h05, 8'h05}, '{8'h71, 8'h00, 8'h01}, '{8'h71, 8'hff, 8'h03},
      '{8'h74, 8'hff, 8'h04}, '{8'h75, 8'h00, 8'h04}, '{8'hf0, 8'h8d, 8'h05},
      '{8'hf0, 8'h12, 8'h12}, '{8'hf1, 8'h27, 8'h27}, '{8'hf3, 8'h5a, 8'h5a},
      '{8'hf2, 8'h03, 8'h03}};

   gpio_port_config_runtime DUT (.clk_sys_in, .ce_in, .srst_in, .stby_srst_in, .rt_addr_in,
      .rt_wr_in, .rt_rd_in, .rt_wdata_in, .rt_rdata_out, .cfg_src_in, .cfg_index_in, .cfg_wr_in,
      .cfg_rd_in, .cfg_wdata_in, .cfg_rdata_out, .pin_in, .pin_drive_out, .pin_oe_out,
      .pullup_en_out, .irq_out, .system_management_interrupt_out);
   gpio_pin_partner ext (.clk_sys_in, .drive_in(pin_drive_out), .oe_in(pin_oe_out),
      .pullup_in(pullup_en_out), .ext_in, .ext_oe_in, .level_out(pin_in));

   ////////////////////////////////////////////////////////////
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_sys_in);
      #1;
   endtask
   task automatic cfg_acc(input logic s, input logic w, input logic [7:0] i, d);
      @(posedge clk_sys_in) #1;
      cfg_src_in = s;
      cfg_index_in = i;
      cfg_wdata_in = d;
      cfg_wr_in = w;
      cfg_rd_in = !w;
      @(posedge clk_sys_in) #1;
      cfg_wr_in = 1'b0;
      cfg_rd_in = 1'b0;
   endtask
   task automatic cfg_r(input logic s, input logic [7:0] i, e);
      cfg_acc(s, 1'b0, i, 8'h00);
      `CHK($sformatf("cfg %h", i), e, cfg_rdata_out)
   endtask
   task automatic rt_acc(input logic w, input logic [4:0] o, input logic [7:0] d);
      @(posedge clk_sys_in) #1;
      rt_addr_in = RT_BASE | {11'h000, o};
      rt_wdata_in = d;
      rt_wr_in = w;
      rt_rd_in = !w;
      @(posedge clk_sys_in) #1;
      rt_wr_in = 1'b0;
      rt_rd_in = 1'b0;
   endtask
   task automatic rt_r(input logic [4:0] o, input logic [7:0] e);
      rt_acc(1'b0, o, 8'h00);
      `CHK($sformatf("rt %h", o), e, rt_rdata_out)
   endtask
   task automatic print_verdict();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask

   ////////////////////////////////////////////////////////////
   initial begin
      clk_sys_in = 1'b0;
      forever #2.5 clk_sys_in = ~clk_sys_in;
   end
   initial begin
      repeat (20000) @(posedge clk_sys_in);
      fails++;
      print_verdict();
   end
   initial begin
      {fails, n_compared} = '0;
      {ce_in, srst_in, stby_srst_in} = 3'h7;
      {rt_wr_in, rt_rd_in, cfg_src_in, cfg_wr_in, cfg_rd_in} = 5'h00;
      {rt_addr_in, rt_wdata_in, cfg_index_in, cfg_wdata_in} = '0;
      ext_in = 56'h0000000000a500;
      ext_oe_in = 56'h0000000000fb00;
      cyc(12);
      {srst_in, stby_srst_in} = 2'h0;
      foreach (rows[k]) begin
         cfg_acc(1'b0, 1'b1, rows[k].i, rows[k].d);
         cfg_r(1'b0, rows[k].i, rows[k].e);
      end
      rt_acc(1'b1, 5'h05, 8'hff);
      rt_acc(1'b1, 5'h02, 8'h00);
      cyc(6);
      rt_r(5'h03, 8'ha1);
      `CHK("oe pin10", 1'b1, pin_oe_out[10])
      rt_acc(1'b1, 5'h04, 8'h04);
      rt_acc(1'b1, 5'h02, 8'h04);
      for (int k = 0; k < 40 && irq_out !== 1'b1; k++) cyc(1);
      `CHK("irq", 1'b1, irq_out)
      `CHK("smi", 1'b1, system_management_interrupt_out)
      rt_r(5'h05, 8'h04);
      rt_r(5'h03, 8'ha5);
      rt_acc(1'b1, 5'h04, 8'h00);
      cyc(4);
      `CHK("irq masked", 1'b0, irq_out)
      rt_acc(1'b1, 5'h04, 8'h04);
      rt_acc(1'b1, 5'h05, 8'h04);
      cyc(4);
      `CHK("irq cleared", 1'b0, irq_out)
      cfg_acc(1'b0, 1'b1, 8'hf1, 8'h37);
      cyc(8);
      rt_acc(1'b1, 5'h05, 8'h04);
      cyc(8);
      rt_r(5'h05, 8'h04);
      cfg_acc(1'b0, 1'b1, 8'hf1, 8'h21);
      cyc(3);
      `CHK("open drain high", 1'b0, pin_oe_out[10])
      rt_acc(1'b1, 5'h02, 8'h00);
      cyc(2);
      `CHK("open drain low", 1'b1, pin_oe_out[10])
      rt_acc(1'b1, 5'h10, 8'hff);
      rt_r(5'h10, 8'h1f);
      cyc(1);
      `CHK("port6 drive", 5'h1f, pin_drive_out[52:48])
      rt_r(5'h11, 8'h00);
      cfg_acc(1'b1, 1'b1, 8'hf0, 8'h45);
      cfg_r(1'b0, 8'hf0, 8'h12);
      cfg_r(1'b1, 8'hf1, 8'h40);
      cfg_acc(1'b1, 1'b1, 8'hf0, 8'h33);
      cfg_r(1'b1, 8'hf1, 8'h00);
      cfg_acc(1'b0, 1'b1, 8'hf1, 8'h2d);
      cfg_acc(1'b0, 1'b1, 8'hf1, 8'h22);
      cfg_r(1'b0, 8'hf1, 8'h2d);
      cfg_acc(1'b0, 1'b1, 8'hf3, 8'h00);
      cfg_r(1'b0, 8'hf3, 8'h5a);
      rt_acc(1'b1, 5'h02, 8'h04);
      rt_r(5'h02, 8'h00);
      srst_in = 1'b1;
      cyc(2);
      srst_in = 1'b0;
      cfg_r(1'b0, 8'h30, 8'h00);
      cfg_r(1'b0, 8'h71, 8'h03);
      cfg_r(1'b0, 8'hf1, 8'h2d);
      stby_srst_in = 1'b1;
      cyc(2);
      stby_srst_in = 1'b0;
      ce_in = 1'b0;
      cfg_acc(1'b0, 1'b1, 8'hf0, 8'h11);
      ce_in = 1'b1;
      cfg_r(1'b0, 8'hf0, 8'h00);
      cfg_r(1'b0, 8'hf1, 8'h00);
      print_verdict();
   end
endmodule
